// file: rtl/cmf_fifo_ctrl.sv
// module: control and status logic of one message fifo or the transmit queue
`timescale 1ns/100ps
// How it works
// - queue empty flag when nothing queued; not-full flag while a slot free
// - message index counts from zero up to depth minus one
// - outcome bits clear on send request set or host zero write
// - outcome bits change only on completion, send request set, host status write or fifo reset
// - queue user address reads the head address
// - payload code picks 8,12,16,20,24,32,48 or 64 bytes
// - depth is field value plus one messages
// - retry field sets limit when global enable set: none, three, unlimited
// - priority field ranks fifos, 31 highest, 0 lowest
// - payload, depth, direction, timestamp fields writable only in configuration mode
// - clear bit resets fifo, self-clears, held in configuration mode
// - send request queues transmit, self-clears when all sent; no effect receiving
// - writing zero to a set send request aborts pending transmission
// - advance bit moves head (transmit) or tail (receive) one message
// - direction bit: one transmit, zero receive, steers all dependent fields
// - matching remote request sets send request when auto reply enabled
// - timestamp enable makes received objects carry timestamp
// - three enables gate occupancy flags according to direction
// - index shows next transmit message or next receive slot
// - each transmission reports abort, arbitration loss, bus error
// - attempts flag only transmit, overflow flag only receive, else zero
// - receive user address reads tail; transmit reads head
module cmf_fifo_ctrl #(
  parameter int IDX_W = 5,
  parameter logic [31:0] RAM_BASE = 32'h0000_0400,
  parameter bit IS_TXQ = 1'b0
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire cmf_pkg::cmf_reg_req_s i_req, // register write port
  output logic [31:0] o_control, // control register read
  output logic [31:0] o_status, // status register read
  output logic [31:0] o_user_addr, // user address read
  input wire logic i_config_mode, // controller in configuration mode
  input wire logic i_retry_global_en, // global retry limit enable
  input wire logic i_engine_push, // engine stored a received message
  input wire logic i_engine_pop, // engine sent a queued message
  input wire cmf_pkg::cmf_tx_outcome_s i_outcome, // transmit outcome
  input wire logic i_attempts_out, // attempts exhausted event
  input wire logic i_overflow, // receive overflow event
  input wire logic i_remote_req, // matching remote request received
  output logic o_send_pending, // fifo wants to transmit
  output logic [4:0] o_tx_priority, // transmit rank
  output logic [1:0] o_retry_limit, // 0 none, 1 three, 3 unlimited
  output logic [6:0] o_payload_bytes, // bytes per message
  output logic o_store_timestamp, // keep timestamp in rx objects
  output logic o_abort_req, // abort pulse to engine
  output logic o_irq // gated occupancy or event flag
);
  localparam int CNT_W = IDX_W + 1;
  initial
  begin
    if (IDX_W != 5) $error("cmf_fifo_ctrl: depth field is five bits");
  end
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  logic [2:0] payload_size_q;
  logic [IDX_W-1:0] fifo_depth_q;
  logic [1:0] retry_limit_q;
  logic [4:0] tx_priority_q;
  logic direction_select_q;
  logic auto_remote_reply_en_q;
  logic rx_timestamp_en_q;
  logic [4:0] ie_q;
  logic fifo_clear_q;
  logic send_request_q;
  cmf_pkg::cmf_state_e state_q;
  logic [CNT_W-1:0] count_q;
  logic [IDX_W-1:0] head_idx;
  logic [IDX_W-1:0] tail_idx;
  logic aborted_status_q;
  logic arbitration_lost_status_q;
  logic bus_error_status_q;
  logic attempts_exhausted_flag_q;
  logic overflow_flag_q;
  logic ctl_wr;
  logic sta_wr;
  logic is_tx;
  logic host_adv;
  logic head_step;
  logic tail_step;
  logic send_set;
  logic send_abort;
  logic [CNT_W-1:0] depth_msgs;
  logic empty;
  logic full;
  logic half;
  logic empty_full_flag;
  logic half_level_flag;
  logic notfull_notempty_flag;
  logic [IDX_W-1:0] msg_index;
  logic [IDX_W-1:0] user_idx;

  assign ctl_wr = i_req.wr && i_req.sel == cmf_pkg::REG_FIFO_CONTROL;
  assign sta_wr = i_req.wr && i_req.sel == cmf_pkg::REG_FIFO_STATUS;
  assign is_tx = IS_TXQ ? 1'b1 : direction_select_q;
  assign host_adv = ctl_wr && i_req.wdata[cmf_pkg::CTL_ADV_BIT] && !fifo_clear_q;
  // receive fifo: host frees a slot at tail, engine fills at head
  assign head_step = is_tx ? host_adv : i_engine_push;
  assign tail_step = is_tx ? i_engine_pop : host_adv;
  assign send_set = is_tx && ((ctl_wr && i_req.wdata[cmf_pkg::CTL_SEND_BIT] && !send_request_q)
                    || (auto_remote_reply_en_q && i_remote_req && !IS_TXQ));
  assign send_abort = ctl_wr && send_request_q && !i_req.wdata[cmf_pkg::CTL_SEND_BIT];

  // ---------------------------------------------------------------
  // configuration-mode fields
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      payload_size_q <= 3'h0;
      fifo_depth_q <= '0;
      direction_select_q <= IS_TXQ;
      rx_timestamp_en_q <= 1'b0;
    end
    else if (ctl_wr && i_config_mode)
    begin
      payload_size_q <= i_req.wdata[cmf_pkg::CTL_PLSZ_LSB +: 3];
      fifo_depth_q <= i_req.wdata[cmf_pkg::CTL_DEPTH_LSB +: IDX_W];
      direction_select_q <= IS_TXQ ? 1'b1 : i_req.wdata[cmf_pkg::CTL_DIR_BIT];
      rx_timestamp_en_q <= IS_TXQ ? 1'b0 : i_req.wdata[cmf_pkg::CTL_TS_BIT];
    end
  end

  // ---------------------------------------------------------------
  // freely writable fields
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      retry_limit_q <= cmf_pkg::RST_RETRY;
      tx_priority_q <= 5'h00;
      auto_remote_reply_en_q <= 1'b0;
      ie_q <= 5'h00;
    end
    else if (ctl_wr)
    begin
      retry_limit_q <= i_req.wdata[cmf_pkg::CTL_RETRY_LSB +: 2];
      tx_priority_q <= i_req.wdata[cmf_pkg::CTL_PRIO_LSB +: 5];
      auto_remote_reply_en_q <= IS_TXQ ? 1'b0 : i_req.wdata[cmf_pkg::CTL_RTR_BIT];
      ie_q <= i_req.wdata[cmf_pkg::CTL_ATIE_BIT:cmf_pkg::CTL_NNIE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // clear and send sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= cmf_pkg::CMF_CLEAR;
      fifo_clear_q <= 1'b1;
      send_request_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        cmf_pkg::CMF_CLEAR:
        begin
          // held while configuring; released once normal operation resumes
          send_request_q <= 1'b0;
          if (!i_config_mode)
          begin
            fifo_clear_q <= 1'b0;
            state_q <= cmf_pkg::CMF_IDLE;
          end
        end
        cmf_pkg::CMF_IDLE, cmf_pkg::CMF_SEND:
        begin
          if (i_config_mode || (ctl_wr && i_req.wdata[cmf_pkg::CTL_CLEAR_BIT]))
          begin
            fifo_clear_q <= 1'b1;
            send_request_q <= 1'b0;
            state_q <= cmf_pkg::CMF_CLEAR;
          end
          else if (send_set)
          begin
            send_request_q <= 1'b1;
            state_q <= cmf_pkg::CMF_SEND;
          end
          else if (send_abort || (send_request_q && i_outcome.done && count_q == CNT_W'(1) && i_engine_pop))
          begin
            send_request_q <= 1'b0;
            state_q <= cmf_pkg::CMF_IDLE;
          end
        end
        default:
        begin
          state_q <= cmf_pkg::CMF_CLEAR;
          fifo_clear_q <= 1'b1;
          send_request_q <= 1'b0;
        end
      endcase
    end
  end
  assign o_abort_req = send_abort && is_tx;

  // ---------------------------------------------------------------
  // pointers and occupancy
  // ---------------------------------------------------------------
  cmf_ring_ptr #(.IDX_W(IDX_W)) u_head (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(fifo_clear_q),
    .i_step(head_step && !full),
    .i_depth_code(fifo_depth_q),
    .o_idx(head_idx)
  );
  cmf_ring_ptr #(.IDX_W(IDX_W)) u_tail (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(fifo_clear_q),
    .i_step(tail_step && !empty),
    .i_depth_code(fifo_depth_q),
    .o_idx(tail_idx)
  );
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || fifo_clear_q)
      count_q <= '0;
    else if ((head_step && !full) && !(tail_step && !empty))
      count_q <= CNT_W'(count_q + 1'b1);
    else if (!(head_step && !full) && (tail_step && !empty))
      count_q <= CNT_W'(count_q - 1'b1);
  end
  assign depth_msgs = CNT_W'({1'b0, fifo_depth_q} + 1'b1);
  assign empty = count_q == '0;
  assign full = count_q == depth_msgs;
  assign half = is_tx ? ({count_q, 1'b0} <= {1'b0, depth_msgs}) : ({count_q, 1'b0} >= {1'b0, depth_msgs});
  assign empty_full_flag = is_tx ? empty : full;
  assign half_level_flag = half;
  assign notfull_notempty_flag = is_tx ? !full : !empty;
  assign msg_index = is_tx ? tail_idx : head_idx;
  assign user_idx = is_tx ? head_idx : tail_idx;

  // ---------------------------------------------------------------
  // transmit outcome and event flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || fifo_clear_q)
    begin
      aborted_status_q <= 1'b0;
      arbitration_lost_status_q <= 1'b0;
      bus_error_status_q <= 1'b0;
    end
    else if (is_tx && i_outcome.done)
    begin
      aborted_status_q <= i_outcome.aborted;
      arbitration_lost_status_q <= i_outcome.arb_lost;
      bus_error_status_q <= i_outcome.bus_err;
    end
    else if (send_set)
    begin
      aborted_status_q <= 1'b0;
      arbitration_lost_status_q <= 1'b0;
      bus_error_status_q <= 1'b0;
    end
    else if (sta_wr)
    begin
      aborted_status_q <= aborted_status_q & i_req.wdata[cmf_pkg::STA_ABT_BIT];
      arbitration_lost_status_q <= arbitration_lost_status_q & i_req.wdata[cmf_pkg::STA_ARB_BIT];
      bus_error_status_q <= bus_error_status_q & i_req.wdata[cmf_pkg::STA_ERR_BIT];
    end
  end
  // event set wins over a host clear in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || fifo_clear_q)
    begin
      attempts_exhausted_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end
    else
    begin
      attempts_exhausted_flag_q <= (is_tx && i_attempts_out) || (attempts_exhausted_flag_q
                                   && !(sta_wr && !i_req.wdata[cmf_pkg::STA_AT_BIT]));
      overflow_flag_q <= (!is_tx && i_overflow) || (overflow_flag_q
                         && !(sta_wr && !i_req.wdata[cmf_pkg::STA_OV_BIT]));
    end
  end

  // ---------------------------------------------------------------
  // engine-facing outputs and read data
  // ---------------------------------------------------------------
  assign o_send_pending = send_request_q && is_tx && !empty;
  assign o_tx_priority = tx_priority_q;
  assign o_retry_limit = !i_retry_global_en ? cmf_pkg::THREE_ATTEMPTS
                       : (retry_limit_q == cmf_pkg::RETRY_OFF) ? cmf_pkg::RETRY_OFF
                       : (retry_limit_q == cmf_pkg::RETRY_THREE) ? cmf_pkg::RETRY_THREE
                       : cmf_pkg::THREE_ATTEMPTS;
  always_comb
  begin
    case (payload_size_q)
      3'h0: o_payload_bytes = 7'h08;
      3'h1: o_payload_bytes = 7'h0C;
      3'h2: o_payload_bytes = 7'h10;
      3'h3: o_payload_bytes = 7'h14;
      3'h4: o_payload_bytes = 7'h18;
      3'h5: o_payload_bytes = 7'h20;
      3'h6: o_payload_bytes = 7'h30;
      default: o_payload_bytes = 7'h40;
    endcase
  end
  assign o_store_timestamp = !is_tx && rx_timestamp_en_q;
  assign o_irq = (ie_q[4] && attempts_exhausted_flag_q) || (ie_q[3] && overflow_flag_q)
               || (ie_q[2] && empty_full_flag) || (ie_q[1] && half_level_flag)
               || (ie_q[0] && notfull_notempty_flag);

  always_comb
  begin
    o_control = 32'h0000_0000;
    o_control[cmf_pkg::CTL_PLSZ_LSB +: 3] = payload_size_q;
    o_control[cmf_pkg::CTL_DEPTH_LSB +: IDX_W] = fifo_depth_q;
    o_control[cmf_pkg::CTL_RETRY_LSB +: 2] = retry_limit_q;
    o_control[cmf_pkg::CTL_PRIO_LSB +: 5] = tx_priority_q;
    o_control[cmf_pkg::CTL_CLEAR_BIT] = fifo_clear_q;
    o_control[cmf_pkg::CTL_SEND_BIT] = send_request_q;
    o_control[cmf_pkg::CTL_DIR_BIT] = is_tx;
    o_control[cmf_pkg::CTL_RTR_BIT] = auto_remote_reply_en_q;
    o_control[cmf_pkg::CTL_TS_BIT] = rx_timestamp_en_q;
    o_control[cmf_pkg::CTL_ATIE_BIT:cmf_pkg::CTL_NNIE_BIT] = ie_q;
    if (IS_TXQ)
    begin
      o_control[cmf_pkg::CTL_OVIE_BIT] = 1'b0;
      o_control[cmf_pkg::CTL_HLIE_BIT] = 1'b0;
    end
  end
  always_comb
  begin
    o_status = 32'h0000_0000;
    o_status[cmf_pkg::STA_INDEX_LSB +: IDX_W] = msg_index;
    o_status[cmf_pkg::STA_ABT_BIT] = aborted_status_q;
    o_status[cmf_pkg::STA_ARB_BIT] = arbitration_lost_status_q;
    o_status[cmf_pkg::STA_ERR_BIT] = bus_error_status_q;
    o_status[cmf_pkg::STA_AT_BIT] = attempts_exhausted_flag_q && is_tx;
    o_status[cmf_pkg::STA_OV_BIT] = overflow_flag_q && !is_tx;
    o_status[cmf_pkg::STA_EF_BIT] = empty_full_flag;
    o_status[cmf_pkg::STA_HL_BIT] = IS_TXQ ? 1'b0 : half_level_flag;
    o_status[cmf_pkg::STA_NN_BIT] = notfull_notempty_flag;
  end
  // address scaled by object size; header overhead omitted for simplicity
  assign o_user_addr = RAM_BASE + 32'(user_idx) * 32'(o_payload_bytes);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  index_range_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_status[12:8] <= fifo_depth_q) else $error("index beyond depth");
  empty_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    is_tx |-> (o_status[2] == (count_q == '0))) else $error("empty flag wrong");
  notfull_flag_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    is_tx |-> (o_status[0] != full)) else $error("not-full flag wrong");
  outcome_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (send_set && !i_outcome.done && !fifo_clear_q) |=> o_status[7:5] == 3'h0)
    else $error("outcome not cleared by send request");
  outcome_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!i_outcome.done && !send_set && !sta_wr && !fifo_clear_q) |=> $stable(o_status[7:5]))
    else $error("outcome changed without cause");
  cfg_lock_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ctl_wr && !i_config_mode) |=> $stable(o_control[31:24])) else $error("config field changed");
  clear_release_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (fifo_clear_q && !i_config_mode) |=> !fifo_clear_q ##0 count_q == '0) else $error("clear stuck");
  abort_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (o_abort_req && !i_config_mode && !i_req.wdata[10]) |=> !send_request_q) else $error("abort ignored");
  rx_send_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !is_tx |-> !o_send_pending) else $error("receive fifo sending");
  count_step_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (head_step && !full && !tail_step && !fifo_clear_q) |=> count_q == $past(count_q) + 1'b1)
    else $error("count did not follow head");
  dir_flags_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    is_tx |-> !o_status[3]) else $error("overflow shown in transmit");
  fill_cov: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) full ##[1:200] empty);
  send_cov: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) send_set ##[1:20] i_outcome.done);
  abort_cov: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) o_abort_req);
endmodule // cmf_fifo_ctrl

// file: rtl/cmf_pkg.sv
// package: register layout, field positions and carrier structs for the message fifo control block
package cmf_pkg;
  // ---------------------------------------------------------------
  // register selects on the register port
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_FIFO_CONTROL = 2'h0;
  localparam logic [1:0] REG_FIFO_STATUS = 2'h1;
  localparam logic [1:0] REG_USER_ADDRESS = 2'h2;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTL_PLSZ_LSB = 29;
  localparam int CTL_DEPTH_LSB = 24;
  localparam int CTL_RETRY_LSB = 21;
  localparam int CTL_PRIO_LSB = 16;
  localparam int CTL_CLEAR_BIT = 10;
  localparam int CTL_SEND_BIT = 9;
  localparam int CTL_ADV_BIT = 8;
  localparam int CTL_DIR_BIT = 7;
  localparam int CTL_RTR_BIT = 6;
  localparam int CTL_TS_BIT = 5;
  localparam int CTL_ATIE_BIT = 4;
  localparam int CTL_OVIE_BIT = 3;
  localparam int CTL_EFIE_BIT = 2;
  localparam int CTL_HLIE_BIT = 1;
  localparam int CTL_NNIE_BIT = 0;
  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int STA_INDEX_LSB = 8;
  localparam int STA_ABT_BIT = 7;
  localparam int STA_ARB_BIT = 6;
  localparam int STA_ERR_BIT = 5;
  localparam int STA_AT_BIT = 4;
  localparam int STA_OV_BIT = 3;
  localparam int STA_EF_BIT = 2;
  localparam int STA_HL_BIT = 1;
  localparam int STA_NN_BIT = 0;
  // ---------------------------------------------------------------
  // reset value and retry limit codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_RETRY = 2'h3;
  localparam logic [1:0] RETRY_OFF = 2'h0;
  localparam logic [1:0] RETRY_THREE = 2'h1;
  localparam logic [1:0] THREE_ATTEMPTS = 2'h3;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [31:0] wdata;
  } cmf_reg_req_s;
  typedef struct packed {
    logic done;
    logic aborted;
    logic arb_lost;
    logic bus_err;
  } cmf_tx_outcome_s;
  typedef enum logic [1:0] {
    CMF_IDLE = 2'b00,
    CMF_CLEAR = 2'b01,
    CMF_SEND = 2'b11
  } cmf_state_e;
endpackage

// file: rtl/cmf_ring_ptr.sv
// module: wrapping message pointer over the configured depth
`timescale 1ns/100ps
module cmf_ring_ptr #(
  parameter int IDX_W = 5
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_sys_rst, // sync reset, active high
  input wire logic i_clear, // return to slot zero
  input wire logic i_step, // advance one message
  input wire logic [IDX_W-1:0] i_depth_code, // depth minus one
  output logic [IDX_W-1:0] o_idx // current slot
);
  initial
  begin
    if (IDX_W < 1 || IDX_W > 8) $error("cmf_ring_ptr: IDX_W out of range");
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || i_clear)
      o_idx <= '0;
    else if (i_step)
      o_idx <= (o_idx == i_depth_code) ? '0 : IDX_W'(o_idx + 1'b1);
  end
endmodule // cmf_ring_ptr

// file: test/cmf_host_model.sv
// host register access model for the message fifo control block
`timescale 1ns/100ps
module cmf_host_model (
  input wire logic i_core_clk, // core clock
  input wire logic [31:0] i_control, // control register view
  output cmf_pkg::cmf_reg_req_s o_req // register write port
);
  initial o_req = '0;
  task automatic put(input logic [1:0] sel, input logic [31:0] data);
    @(posedge i_core_clk);
    #1 o_req = '{1'b1, sel, data};
    @(posedge i_core_clk);
    #1 o_req.wr = 1'b0;
    // released word toggles so a stale value is never taken
    o_req.wdata = ~data;
  endtask
  // polls at most 20 cycles for the clear bit to read back zero
  task automatic wait_clear(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(posedge i_core_clk);
      #1 ok = i_control[cmf_pkg::CTL_CLEAR_BIT] === 1'b0;
    end
  endtask
endmodule // cmf_host_model

// file: test/testbench.sv
// testbench: host and engine stimulus against a behavioural fifo model
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] BASE = 32'h0000_0400;
  localparam logic [1:0] CTL = cmf_pkg::REG_FIFO_CONTROL;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_config_mode = 1'b1, i_retry_global_en = 1'b1;
  logic i_engine_push = 1'b0, i_engine_pop = 1'b0, i_attempts_out = 1'b0, i_overflow = 1'b0, i_remote_req = 1'b0;
  cmf_pkg::cmf_reg_req_s i_req;
  cmf_pkg::cmf_tx_outcome_s i_outcome = '0;
  logic [31:0] o_control, o_status, o_user_addr;
  logic [6:0] o_payload_bytes;
  logic [4:0] o_tx_priority;
  logic [1:0] o_retry_limit;
  logic o_send_pending, o_store_timestamp, o_abort_req, o_irq;
  logic [31:0] lfsr = 32'hD12E;
  int bad_count = 0, checked = 0, cnt = 0, head = 0, tail = 0, depth = 4, bytes = 64, dir = 1;
  int sizes[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
  int lim[4] = '{0, 1, 3, 3};
  bit ok;
  always #5 i_core_clk = ~i_core_clk;
  cmf_host_model host (.i_core_clk(i_core_clk), .i_control(o_control), .o_req(i_req));
  cmf_fifo_ctrl #(.IDX_W(5), .RAM_BASE(BASE), .IS_TXQ(1'b0)) uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_req(i_req), .o_control(o_control), .o_status(o_status), .o_user_addr(o_user_addr),
    .i_config_mode(i_config_mode), .i_retry_global_en(i_retry_global_en), .i_engine_push(i_engine_push),
    .i_engine_pop(i_engine_pop), .i_outcome(i_outcome), .i_attempts_out(i_attempts_out), .i_overflow(i_overflow),
    .i_remote_req(i_remote_req), .o_send_pending(o_send_pending), .o_tx_priority(o_tx_priority),
    .o_retry_limit(o_retry_limit), .o_payload_bytes(o_payload_bytes), .o_store_timestamp(o_store_timestamp),
    .o_abort_req(o_abort_req), .o_irq(o_irq));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic hit(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  // flags, index and address from the model's count and pointers
  task automatic occ();
    logic [31:0] s;
    s = '0;
    s[12:8] = 5'(dir ? tail : head);
    s[2] = dir ? cnt == 0 : cnt == depth;
    s[1] = dir ? 2 * cnt <= depth : 2 * cnt >= depth;
    s[0] = dir ? cnt < depth : cnt != 0;
    cmp("status", s, o_status & 32'h0000_1F07);
    cmp("address", BASE + 32'((dir ? head : tail) * bytes), o_user_addr);
    cmp("irq", {31'h0, |(s[2:0] & 3'h5)}, {31'h0, o_irq});
  endtask
  // aborted outcomes leave the message in place
  task automatic pop(input logic [2:0] res, input int mv);
    i_engine_pop = 1'(mv);
    i_outcome = {1'b1, res};
    tick();
    i_engine_pop = 1'b0;
    i_outcome = '0;
    tail = (tail + mv) % depth;
    cnt -= mv;
    cmp("outcome", {29'h0, res}, {29'h0, o_status[7:5]});
    occ();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    #1 i_sys_rst = 1'b0;
    cmp("reset control", 32'h0060_0400, o_control);
    for (int c = 0; c < 8; c++)
    begin
      host.put(CTL, {3'(c), 5'h03, 11'h060, 13'h00A5});
      cmp("payload", 32'(sizes[c]), {25'h0, o_payload_bytes});
    end
    // enable is stored, but a transmit fifo holds no received objects
    cmp("timestamp tx", 32'h0, {31'h0, o_store_timestamp});
    i_config_mode = 1'b0;
    host.wait_clear(ok);
    cmp("clear done", 32'h1, {31'h0, ok});
    for (int r = 0; r < 5; r++)
    begin
      logic [4:0] p;
      p = 5'(rnd());
      i_retry_global_en = 1'(r < 4);
      host.put(CTL, {9'h000, 2'(r), p, 16'h0005});
      cmp("retry", r < 4 ? lim[r & 3] : 3, {30'h0, o_retry_limit});
      cmp("priority", {27'h0, p}, {27'h0, o_tx_priority});
      cmp("locked", 32'hE300_00A0, o_control & 32'hFF00_00A0);
    end
    $display("test config done");
    occ();
    for (int n = 0; n < 5; n++)
    begin
      host.put(CTL, 32'h0000_0105);
      head = (head + (cnt < depth ? 1 : 0)) % depth;
      cnt = cnt + (cnt < depth ? 1 : 0);
      occ();
    end
    host.put(CTL, 32'h0000_0205);
    cmp("pending", 32'h1, {31'h0, o_send_pending});
    pop(3'h3, 1);
    fork
      host.put(CTL, 32'h0000_0005);
      begin
        @(posedge i_core_clk);
        @(negedge i_core_clk);
        cmp("abort", 32'h1, {31'h0, o_abort_req});
      end
    join
    pop(3'h4, 0);
    // send bit rises from zero again, so the stale outcome must go
    host.put(CTL, 32'h0000_0205);
    cmp("cleared by send", 32'h0, {29'h0, o_status[7:5]});
    pop(3'h4, 0);
    host.put(cmf_pkg::REG_FIFO_STATUS, 32'h0);
    cmp("cleared by host", 32'h0, {29'h0, o_status[7:5]});
    host.put(CTL, 32'h0000_0045);
    hit(i_remote_req);
    cmp("remote reply", 32'h1, {31'h0, o_control[9]});
    repeat (3) pop(3'h0, 1);
    cmp("send done", 32'h0, {31'h0, o_control[9]});
    hit(i_attempts_out);
    hit(i_overflow);
    cmp("tx events", 32'h10, o_status & 32'h18);
    $display("test transmit done");
    i_config_mode = 1'b1;
    tick();
    host.put(CTL, 32'h0100_0025);
    i_config_mode = 1'b0;
    host.wait_clear(ok);
    cmp("timestamp rx", 32'h1, {31'h0, o_store_timestamp});
    {dir, depth, bytes, cnt, head} = {32'd0, 32'd2, 32'd8, 32'd0, 32'd0};
    tail = 0;
    repeat (2)
    begin
      hit(i_engine_push);
      head = (head + 1) % depth;
      cnt++;
      occ();
    end
    host.put(CTL, 32'h0000_0305);
    tail = 1;
    cnt = 1;
    occ();
    cmp("rx pending", 32'h0, {31'h0, o_send_pending});
    hit(i_overflow);
    cmp("rx events", 32'h08, o_status & 32'h18);
    $display("test receive done");
    conclude();
  end
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule // testbench
